// file: design/upr_map.svh
/*
 Widths, masks and timing counts of the USB port ownership router.
 Assumes a 200 MHz core clock; included by the router and its port slice.
*/
`ifndef UPR_MAP_SVH
`define UPR_MAP_SVH

`define UPR_NUM_PORTS       4
`define UPR_DATA_W          8
`define UPR_PSC_W           32
// Port register bits that only the enhanced controller defines
`define UPR_PSC_HS_ONLY     32'h000F_2000
// Companion bits after reset: every port owned by the legacy side
`define UPR_COMP_RST        4'hF
`define UPR_CLK_PERIOD_NS   5
// Break-before-make gap on an ownership change
`define UPR_GAP_NS          10
`define UPR_GAP_CYC         ((`UPR_GAP_NS + `UPR_CLK_PERIOD_NS - 1) / `UPR_CLK_PERIOD_NS)

`endif

// file: design/upr_pkg.sv
/*
 Types shared by the USB port ownership router and its port slice.
 Assumes nothing of its surroundings.
*/
package upr_pkg;

   typedef enum logic [1:0] {
      UPR_SPD_FS,
      UPR_SPD_LS,
      UPR_SPD_HS
   } upr_speed_t;

   typedef enum logic [1:0] {
      UPR_PS_OFF,
      UPR_PS_LEGACY,
      UPR_PS_GAP,
      UPR_PS_HS
   } upr_port_state_t;

endpackage : upr_pkg

// file: design/upr_port_slice.sv
/*
 One physical downstream port: ownership state and transceiver path switch.
 Assumes all controller and transceiver signals are on the core clock.
*/
`timescale 1ns/10ps
`include "upr_map.svh"

module upr_port_slice
   import upr_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    enable,
   input  wire logic                    want_hs,
   input  wire logic [`UPR_DATA_W-1:0]  hs_tx_data,
   input  wire logic                    hs_tx_valid,
   input  wire logic [`UPR_DATA_W-1:0]  ls_tx_data,
   input  wire logic                    ls_tx_valid,
   input  wire logic                    ls_low_speed,
   input  wire logic [`UPR_DATA_W-1:0]  xcvr_rx_data,
   input  wire logic                    xcvr_rx_valid,
   output logic      [`UPR_DATA_W-1:0]  xcvr_tx_data,
   output logic                         xcvr_tx_valid,
   output upr_speed_t                   xcvr_speed,
   output logic      [`UPR_DATA_W-1:0]  rx_data,
   output logic                         hs_rx_valid,
   output logic                         ls_rx_valid,
   output logic                         owner_hs,
   output logic                         owner_ls
);

   upr_port_state_t         state_r, state_nxt, target;
   logic [1:0]              gap_r, gap_nxt;
   logic [`UPR_DATA_W-1:0]  tx_data_nxt;
   logic                    tx_valid_nxt;
   upr_speed_t              speed_nxt;

   assign target   = !enable ? UPR_PS_OFF : (want_hs ? UPR_PS_HS : UPR_PS_LEGACY);
   assign owner_hs = (state_r == UPR_PS_HS);
   assign owner_ls = (state_r == UPR_PS_LEGACY);

   // Never jump between owners: pass through a quiet gap first
   always_comb begin
      state_nxt = state_r;
      gap_nxt   = gap_r;
      unique case (state_r)
         UPR_PS_GAP: begin
            if (gap_r == 2'h0) begin
               state_nxt = target;
            end else begin
               gap_nxt = gap_r - 2'h1;
            end
         end
         UPR_PS_OFF, UPR_PS_LEGACY, UPR_PS_HS: begin
            if (state_r != target) begin
               state_nxt = UPR_PS_GAP;
               gap_nxt   = 2'(`UPR_GAP_CYC - 1);
            end
         end
      endcase
   end

   // One transceiver set, fed by whichever controller owns the port
   assign tx_data_nxt  = owner_hs ? hs_tx_data : ls_tx_data;
   assign tx_valid_nxt = enable & ((owner_hs & hs_tx_valid) | (owner_ls & ls_tx_valid));
   assign speed_nxt    = owner_hs ? UPR_SPD_HS :
                         (ls_low_speed ? UPR_SPD_LS : UPR_SPD_FS);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= UPR_PS_LEGACY;
         gap_r   <= 2'h0;
      end else begin
         state_r <= state_nxt;
         gap_r   <= gap_nxt;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xcvr_tx_data  <= '0;
         xcvr_tx_valid <= 1'b0;
         xcvr_speed    <= UPR_SPD_FS;
         rx_data       <= '0;
         hs_rx_valid   <= 1'b0;
         ls_rx_valid   <= 1'b0;
      end else begin
         xcvr_tx_data  <= tx_data_nxt;
         xcvr_tx_valid <= tx_valid_nxt;
         xcvr_speed    <= speed_nxt;
         rx_data       <= xcvr_rx_data;
         hs_rx_valid   <= owner_hs & xcvr_rx_valid;
         ls_rx_valid   <= owner_ls & xcvr_rx_valid;
      end
   end

   AST_NO_DIRECT_SWAP: assert property (@(posedge clock) disable iff (rst)
      $fell(owner_ls) |-> !owner_hs ##1 !owner_hs)
      else $error("port moved between owners without a gap");
   AST_NO_DIRECT_RETURN: assert property (@(posedge clock) disable iff (rst)
      $fell(owner_hs) |-> !owner_ls ##1 !owner_ls)
      else $error("port returned to legacy without a gap");
   AST_HS_PATH: assert property (@(posedge clock) disable iff (rst)
      owner_hs && hs_tx_valid && enable |=> xcvr_tx_valid && xcvr_tx_data == $past(hs_tx_data))
      else $error("high-speed data not forwarded to transceiver");
   AST_LS_SPEED: assert property (@(posedge clock) disable iff (rst)
      owner_ls |=> xcvr_speed != UPR_SPD_HS)
      else $error("legacy-owned port set to high speed");
   AST_HS_SPEED: assert property (@(posedge clock) disable iff (rst)
      owner_hs |=> xcvr_speed == UPR_SPD_HS)
      else $error("high-speed-owned port not at high speed");
   AST_UNUSED_QUIET: assert property (@(posedge clock) disable iff (rst)
      !enable |=> !xcvr_tx_valid)
      else $error("unused port transmitted");

   COV_TO_HS: cover property (@(posedge clock) disable iff (rst)
      owner_ls ##[1:4] owner_hs);
   COV_TO_LS: cover property (@(posedge clock) disable iff (rst)
      owner_hs ##[1:4] owner_ls);

endmodule : upr_port_slice

// file: design/upr_router.sv
/*
 USB port ownership router: four physical ports shared between the
 enhanced controller and two legacy controllers.
 Assumes controllers, transceiver logic and the port registers run on clock;
 sys_reset and two_port_mode arrive from pins and are synchronised here.
*/
`timescale 1ns/10ps
`include "upr_map.svh"

// Operation
// - Each of four ports is muxed between enhanced and legacy controllers.
// - Ports one, three go to legacy one; ports two, four to legacy two.
// - Power-on reset hands every port to the legacy controllers; system reset hands every port in use to them.
// - Ownership follows configure and companion bits held for the enhanced driver.
// - Legacy writes to a port's register are dropped while enhanced owns it.
// - Enhanced-only port register bits are hidden from legacy reads.
// - A legacy-owned port runs at full or low speed only.
// - An enhanced-owned port runs at high speed.
// - In two-port mode ports three and four stay idle.
module upr_router
   import upr_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          sys_reset,
   input  wire logic          two_port_mode,
   input  wire logic          ehci_cf_wr,
   input  wire logic          ehci_cf_wdata,
   input  wire logic [3:0]    ehci_comp_wr,
   input  wire logic [3:0]    ehci_comp_wdata,
   output logic               ehci_cf,
   output logic      [3:0]    ehci_comp,
   input  wire logic [31:0]   ehci_tx_data,
   input  wire logic [3:0]    ehci_tx_valid,
   output logic      [31:0]   ehci_rx_data,
   output logic      [3:0]    ehci_rx_valid,
   input  wire logic [3:0]    ehci_psc_wr,
   input  wire logic [127:0]  ehci_psc_wdata,
   input  wire logic [15:0]   ohci1_tx_data,
   input  wire logic [1:0]    ohci1_tx_valid,
   input  wire logic [1:0]    ohci1_low_speed,
   output logic      [15:0]   ohci1_rx_data,
   output logic      [1:0]    ohci1_rx_valid,
   input  wire logic [1:0]    ohci1_psc_wr,
   input  wire logic [63:0]   ohci1_psc_wdata,
   output logic      [63:0]   ohci1_psc_rdata,
   input  wire logic [15:0]   ohci2_tx_data,
   input  wire logic [1:0]    ohci2_tx_valid,
   input  wire logic [1:0]    ohci2_low_speed,
   output logic      [15:0]   ohci2_rx_data,
   output logic      [1:0]    ohci2_rx_valid,
   input  wire logic [1:0]    ohci2_psc_wr,
   input  wire logic [63:0]   ohci2_psc_wdata,
   output logic      [63:0]   ohci2_psc_rdata,
   output logic      [3:0]    psc_wr,
   output logic      [127:0]  psc_wdata,
   input  wire logic [127:0]  psc_rdata,
   output logic      [31:0]   xcvr_tx_data,
   output logic      [3:0]    xcvr_tx_valid,
   output logic      [7:0]    xcvr_speed,
   input  wire logic [31:0]   xcvr_rx_data,
   input  wire logic [3:0]    xcvr_rx_valid,
   output logic      [3:0]    port_owner_hs
);

   logic          sysrst_m_r, sysrst_s_r;
   logic          twop_m_r, twop_s_r;
   logic          cf_r;
   logic [3:0]    comp_r;
   logic [3:0]    port_used;
   logic [3:0]    want_hs;
   logic [3:0]    owner_ls;
   logic [3:0]    ls_tx_valid, ls_low, ls_psc_wr, ls_rx_valid;
   logic [31:0]   ls_tx_data, rx_data;
   logic [127:0]  ls_psc_wdata, ls_psc_rdata;
   logic [3:0]    psc_wr_nxt;
   logic [127:0]  psc_wdata_nxt;

   // Pin inputs: the first stage feeds only the second
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sysrst_m_r <= 1'b0;
         sysrst_s_r <= 1'b0;
         twop_m_r   <= 1'b0;
         twop_s_r   <= 1'b0;
      end else begin
         sysrst_m_r <= sys_reset;
         sysrst_s_r <= sysrst_m_r;
         twop_m_r   <= two_port_mode;
         twop_s_r   <= twop_m_r;
      end
   end

   // Clearing the configure flag returns all ports, as software expects
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cf_r   <= 1'b0;
         comp_r <= `UPR_COMP_RST;
      end else if (sysrst_s_r) begin
         cf_r   <= 1'b0;
         comp_r <= `UPR_COMP_RST;
      end else begin
         if (ehci_cf_wr) begin
            cf_r <= ehci_cf_wdata;
         end
         if (ehci_cf_wr && !ehci_cf_wdata) begin
            comp_r <= `UPR_COMP_RST;
         end else begin
            comp_r <= (comp_r & ~ehci_comp_wr) | (ehci_comp_wdata & ehci_comp_wr);
         end
      end
   end

   assign ehci_cf   = cf_r;
   assign ehci_comp = comp_r;
   assign port_used = twop_s_r ? 4'h3 : 4'hF;
   assign want_hs   = {4{cf_r}} & ~comp_r;

   genvar p;
   generate
      for (p = 0; p < `UPR_NUM_PORTS; p++) begin : g_port
         localparam int L = p / 2;
         // Even index is port one or three, owned by the first legacy controller
         if (p % 2 == 0) begin : g_l1
            assign ls_tx_data[p*8 +: 8]      = ohci1_tx_data[L*8 +: 8];
            assign ls_tx_valid[p]            = ohci1_tx_valid[L];
            assign ls_low[p]                 = ohci1_low_speed[L];
            assign ls_psc_wr[p]              = ohci1_psc_wr[L];
            assign ls_psc_wdata[p*32 +: 32]  = ohci1_psc_wdata[L*32 +: 32];
            assign ohci1_rx_data[L*8 +: 8]   = rx_data[p*8 +: 8];
            assign ohci1_rx_valid[L]         = ls_rx_valid[p];
            assign ohci1_psc_rdata[L*32 +: 32] = ls_psc_rdata[p*32 +: 32];
         end else begin : g_l2
            assign ls_tx_data[p*8 +: 8]      = ohci2_tx_data[L*8 +: 8];
            assign ls_tx_valid[p]            = ohci2_tx_valid[L];
            assign ls_low[p]                 = ohci2_low_speed[L];
            assign ls_psc_wr[p]              = ohci2_psc_wr[L];
            assign ls_psc_wdata[p*32 +: 32]  = ohci2_psc_wdata[L*32 +: 32];
            assign ohci2_rx_data[L*8 +: 8]   = rx_data[p*8 +: 8];
            assign ohci2_rx_valid[L]         = ls_rx_valid[p];
            assign ohci2_psc_rdata[L*32 +: 32] = ls_psc_rdata[p*32 +: 32];
         end

         upr_port_slice u_slice (
            .clock         (clock),
            .rst           (rst),
            .enable        (port_used[p]),
            .want_hs       (want_hs[p]),
            .hs_tx_data    (ehci_tx_data[p*8 +: 8]),
            .hs_tx_valid   (ehci_tx_valid[p]),
            .ls_tx_data    (ls_tx_data[p*8 +: 8]),
            .ls_tx_valid   (ls_tx_valid[p]),
            .ls_low_speed  (ls_low[p]),
            .xcvr_rx_data  (xcvr_rx_data[p*8 +: 8]),
            .xcvr_rx_valid (xcvr_rx_valid[p]),
            .xcvr_tx_data  (xcvr_tx_data[p*8 +: 8]),
            .xcvr_tx_valid (xcvr_tx_valid[p]),
            .xcvr_speed    (xcvr_speed[p*2 +: 2]),
            .rx_data       (rx_data[p*8 +: 8]),
            .hs_rx_valid   (ehci_rx_valid[p]),
            .ls_rx_valid   (ls_rx_valid[p]),
            .owner_hs      (port_owner_hs[p]),
            .owner_ls      (owner_ls[p])
         );

         assign ehci_rx_data[p*8 +: 8] = rx_data[p*8 +: 8];

         // Only the owner may write; a legacy write to an enhanced port is lost
         assign psc_wr_nxt[p] = port_owner_hs[p] ? ehci_psc_wr[p] :
                                (owner_ls[p] & ls_psc_wr[p]);
         assign psc_wdata_nxt[p*32 +: 32] = port_owner_hs[p] ? ehci_psc_wdata[p*32 +: 32] :
                                            ls_psc_wdata[p*32 +: 32];

         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               psc_wr[p]                  <= 1'b0;
               psc_wdata[p*32 +: 32]      <= '0;
               ls_psc_rdata[p*32 +: 32]   <= '0;
            end else begin
               psc_wr[p]                  <= psc_wr_nxt[p];
               psc_wdata[p*32 +: 32]      <= psc_wdata_nxt[p*32 +: 32];
               ls_psc_rdata[p*32 +: 32]   <= psc_rdata[p*32 +: 32] & ~`UPR_PSC_HS_ONLY;
            end
         end
      end
   endgenerate

   AST_RESET_LEGACY: assert property (@(posedge clock) disable iff (rst)
      sysrst_s_r |=> !cf_r && comp_r == 4'hF ##[1:3] port_owner_hs == 4'h0)
      else $error("system reset did not return ports to legacy");
   AST_OWNER_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
      (want_hs & port_used) == 4'hF [*5] |-> port_owner_hs == 4'hF)
      else $error("enhanced ownership not granted within gap");
   AST_NO_HS_WITHOUT_CF: assert property (@(posedge clock) disable iff (rst)
      !cf_r [*4] |-> port_owner_hs == 4'h0)
      else $error("enhanced owns a port while unconfigured");
   AST_ONE_OWNER: assert property (@(posedge clock) disable iff (rst)
      (port_owner_hs & owner_ls) == 4'h0)
      else $error("port owned by both controllers");
   AST_LEGACY_WR_BLOCK: assert property (@(posedge clock) disable iff (rst)
      port_owner_hs[0] && ohci1_psc_wr[0] && !ehci_psc_wr[0] |=> !psc_wr[0])
      else $error("legacy write reached an enhanced-owned port");
   AST_LEGACY_WR_PASS: assert property (@(posedge clock) disable iff (rst)
      owner_ls[1] && ohci2_psc_wr[0] |=> psc_wr[1] && psc_wdata[63:32] == $past(ohci2_psc_wdata[31:0]))
      else $error("second legacy write not routed to port two");
   AST_HIDE_HS_BITS: assert property (@(posedge clock) disable iff (rst)
      ((ohci1_psc_rdata[31:0] | ohci2_psc_rdata[63:32]) & `UPR_PSC_HS_ONLY) == 32'h0000_0000)
      else $error("enhanced-only bits visible to legacy");
   AST_PORT3_MAP: assert property (@(posedge clock) disable iff (rst)
      owner_ls[2] && xcvr_rx_valid[2] |=> ohci1_rx_valid[1] && !ehci_rx_valid[2])
      else $error("port three not routed to first legacy controller");
   AST_TWO_PORT_IDLE: assert property (@(posedge clock) disable iff (rst)
      twop_s_r [*2] |-> xcvr_tx_valid[3:2] == 2'h0)
      else $error("port three or four active in two-port mode");

   COV_ALL_HS: cover property (@(posedge clock) disable iff (rst) port_owner_hs == 4'hF);
   COV_TWO_PORT: cover property (@(posedge clock) disable iff (rst) twop_s_r && port_owner_hs[1]);
   COV_SYSRST_HS: cover property (@(posedge clock) disable iff (rst) sysrst_s_r && port_owner_hs != 4'h0);

endmodule : upr_router

// file: tb/upr_xcvr_model.sv
/*
 Far-side model: four transceivers and the four port status registers.
 Assumes the router's clock and reset, and registered transmit and write paths.
*/
`timescale 1ns/10ps

module upr_xcvr_model (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic [31:0]   xcvr_tx_data,
   input  wire logic [3:0]    xcvr_tx_valid,
   output logic      [31:0]   xcvr_rx_data,
   output logic      [3:0]    xcvr_rx_valid,
   input  wire logic [3:0]    psc_wr,
   input  wire logic [127:0]  psc_wdata,
   output logic      [127:0]  psc_rdata
);
   // Echo inverted; idle lanes toggle so stale bytes never pass for data
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xcvr_rx_valid <= 4'h0;
         xcvr_rx_data  <= 32'h0;
         psc_rdata     <= 128'h0;
      end else begin
         xcvr_rx_valid <= xcvr_tx_valid;
         for (int p = 0; p < 4; p++) begin
            xcvr_rx_data[p*8+:8] <= xcvr_tx_valid[p] ? ~xcvr_tx_data[p*8+:8]
                                                     : ~xcvr_rx_data[p*8+:8];
            if (psc_wr[p]) begin
               psc_rdata[p*32+:32] <= psc_wdata[p*32+:32];
            end
         end
      end
   end
endmodule : upr_xcvr_model

// file: tb/upr_router_tb_top.sv
/*
 Self-checking bench of the port ownership router with a far-side model.
 Assumes the router's contract of registered outputs and a 200 MHz clock.
*/
`timescale 1ns/10ps
`include "upr_map.svh"

module upr_router_tb_top
   import upr_pkg::*;
;
   logic          clock, rst, sys_reset, two_port_mode, ehci_cf_wr, ehci_cf_wdata, ehci_cf;
   logic [3:0]    ehci_comp_wr, ehci_comp_wdata, ehci_comp, ehci_tx_valid, ehci_rx_valid;
   logic [3:0]    ehci_psc_wr, psc_wr, xcvr_tx_valid, xcvr_rx_valid, port_owner_hs;
   logic [31:0]   ehci_tx_data, ehci_rx_data, xcvr_tx_data, xcvr_rx_data;
   logic [127:0]  ehci_psc_wdata, psc_wdata, psc_rdata;
   logic [1:0]    ohci1_tx_valid, ohci1_low_speed, ohci1_rx_valid, ohci1_psc_wr;
   logic [1:0]    ohci2_tx_valid, ohci2_low_speed, ohci2_rx_valid, ohci2_psc_wr;
   logic [15:0]   ohci1_tx_data, ohci1_rx_data, ohci2_tx_data, ohci2_rx_data;
   logic [63:0]   ohci1_psc_wdata, ohci1_psc_rdata, ohci2_psc_wdata, ohci2_psc_rdata;
   logic [7:0]    xcvr_speed;
   logic [9:0]    exp_q[$];
   integer        seed = 32'hBE78;
   int            fails = 0;
   int            tests_run = 0;

   upr_router dut (.clock, .rst, .sys_reset, .two_port_mode, .ehci_cf_wr, .ehci_cf_wdata,
      .ehci_comp_wr, .ehci_comp_wdata, .ehci_cf, .ehci_comp, .ehci_tx_data, .ehci_tx_valid,
      .ehci_rx_data, .ehci_rx_valid, .ehci_psc_wr, .ehci_psc_wdata, .ohci1_tx_data,
      .ohci1_tx_valid, .ohci1_low_speed, .ohci1_rx_data, .ohci1_rx_valid, .ohci1_psc_wr,
      .ohci1_psc_wdata, .ohci1_psc_rdata, .ohci2_tx_data, .ohci2_tx_valid, .ohci2_low_speed,
      .ohci2_rx_data, .ohci2_rx_valid, .ohci2_psc_wr, .ohci2_psc_wdata, .ohci2_psc_rdata,
      .psc_wr, .psc_wdata, .psc_rdata, .xcvr_tx_data, .xcvr_tx_valid, .xcvr_speed,
      .xcvr_rx_data, .xcvr_rx_valid, .port_owner_hs);

   upr_xcvr_model far (.clock, .rst, .xcvr_tx_data, .xcvr_tx_valid, .xcvr_rx_data,
      .xcvr_rx_valid, .psc_wr, .psc_wdata, .psc_rdata);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input bit ok, input string msg);
      tests_run++;
      if (!ok) begin
         fails++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk

   // Transmit seen at a transceiver must be the oldest expected byte
   always @(posedge clock) begin
      #1;
      for (int p = 0; p < 4; p++) begin
         if (xcvr_tx_valid[p] === 1'b1) begin
            if (exp_q.size() == 0) chk(1'b0, "transmit from non-owner");
            else chk(exp_q.pop_front() === {p[1:0], xcvr_tx_data[p*8+:8]}, "tx path");
         end
      end
   end

   // src 0 enhanced (idx is port), 1 and 2 legacy lanes
   task automatic send(input int src, input int idx, input bit pass);
      logic [7:0] d;
      int         p;
      bit         got;
      d = 8'($random(seed));
      p = (src == 0) ? idx : idx * 2 + src - 1;
      got = 1'b0;
      if (pass) exp_q.push_back({p[1:0], d});
      @(negedge clock);
      case (src)
         0: begin ehci_tx_data[p*8+:8] = d; ehci_tx_valid[p] = 1'b1; end
         1: begin ohci1_tx_data[idx*8+:8] = d; ohci1_tx_valid[idx] = 1'b1; end
         default: begin ohci2_tx_data[idx*8+:8] = d; ohci2_tx_valid[idx] = 1'b1; end
      endcase
      @(negedge clock);
      ehci_tx_valid = 4'h0;
      ohci1_tx_valid = 2'h0;
      ohci2_tx_valid = 2'h0;
      for (int k = 0; k < 8; k++) begin
         @(negedge clock);
         case (src)
            0: got |= ehci_rx_valid[p] === 1'b1 && ehci_rx_data[p*8+:8] === ~d;
            1: got |= ohci1_rx_valid[idx] === 1'b1 && ohci1_rx_data[idx*8+:8] === ~d;
            default: got |= ohci2_rx_valid[idx] === 1'b1 && ohci2_rx_data[idx*8+:8] === ~d;
         endcase
      end
      chk(got == pass, "receive routing");
   endtask : send

   task automatic pscw(input int src, input int p, input logic [31:0] v, input bit pass);
      bit seen;
      seen = 1'b0;
      @(negedge clock);
      case (src)
         0: begin ehci_psc_wr[p] = 1'b1; ehci_psc_wdata[p*32+:32] = v; end
         1: begin ohci1_psc_wr[p/2] = 1'b1; ohci1_psc_wdata[(p/2)*32+:32] = v; end
         default: begin ohci2_psc_wr[p/2] = 1'b1; ohci2_psc_wdata[(p/2)*32+:32] = v; end
      endcase
      @(negedge clock);
      ehci_psc_wr = 4'h0;
      ohci1_psc_wr = 2'h0;
      ohci2_psc_wr = 2'h0;
      for (int k = 0; k < 3; k++) begin
         seen |= psc_wr[p] === 1'b1 && psc_wdata[p*32+:32] === v;
         @(negedge clock);
      end
      chk(seen == pass, "port register write gating");
   endtask : pscw

   task automatic own_wr(input logic cfw, input logic cfd, input logic [3:0] cw,
                         input logic [3:0] cd);
      @(negedge clock);
      ehci_cf_wr = cfw;
      ehci_cf_wdata = cfd;
      ehci_comp_wr = cw;
      ehci_comp_wdata = cd;
      @(negedge clock);
      ehci_cf_wr = 1'b0;
      ehci_comp_wr = 4'h0;
   endtask : own_wr

   // Bounded wait on the ownership outcome
   task automatic wait_own(input logic [3:0] e);
      for (int k = 0; k < 12 && port_owner_hs !== e; k++) @(negedge clock);
      chk(port_owner_hs === e, "ownership not reached");
   endtask : wait_own

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_of_test();
   end

   initial begin
      {rst, sys_reset, two_port_mode, ehci_cf_wr, ehci_cf_wdata} = 5'b10000;
      {ehci_comp_wr, ehci_comp_wdata, ehci_tx_valid, ehci_psc_wr} = 16'h0;
      {ehci_tx_data, ehci_psc_wdata} = 160'h0;
      {ohci1_tx_valid, ohci1_low_speed, ohci1_psc_wr, ohci1_tx_data} = 22'h0;
      {ohci2_tx_valid, ohci2_low_speed, ohci2_psc_wr, ohci2_tx_data} = 22'h0;
      {ohci1_psc_wdata, ohci2_psc_wdata} = 128'h0;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      chk(port_owner_hs === 4'h0 && ehci_comp === `UPR_COMP_RST, "reset owner");
      for (int i = 0; i < 2; i++) begin
         send(1, i, 1'b1);
         send(2, i, 1'b1);
         send(0, i * 2, 1'b0);
      end
      ohci1_low_speed = 2'b01;
      ohci2_low_speed = 2'b10;
      repeat (3) @(negedge clock);
      chk(xcvr_speed === {UPR_SPD_LS, UPR_SPD_FS, UPR_SPD_FS, UPR_SPD_LS}, "legacy speed");
      pscw(2, 1, 32'hFFFF_FFFF, 1'b1);
      repeat (2) @(negedge clock);
      chk(ohci2_psc_rdata[31:0] === ~(`UPR_PSC_HS_ONLY), "hidden bits");
      own_wr(1'b1, 1'b1, 4'hF, 4'h0);
      own_wr(1'b0, 1'b0, 4'hF, 4'h0);
      wait_own(4'hF);
      repeat (2) @(negedge clock);
      chk(xcvr_speed === {4{UPR_SPD_HS}}, "high speed");
      for (int i = 0; i < 4; i++) send(0, i, 1'b1);
      send(1, 1, 1'b0);
      send(2, 0, 1'b0);
      pscw(1, 0, $random(seed), 1'b0);
      pscw(0, 0, 32'hFFFF_FFFF, 1'b1);
      repeat (2) @(negedge clock);
      chk(ohci1_psc_rdata[31:0] === ~(`UPR_PSC_HS_ONLY), "hidden bits");
      own_wr(1'b0, 1'b0, 4'h1, 4'h1);
      wait_own(4'hE);
      // Enhanced lets go at once, legacy takes over only after the gap
      repeat (2) @(negedge clock);
      send(1, 0, 1'b1);
      sys_reset = 1'b1;
      repeat (4) @(negedge clock);
      wait_own(4'h0);
      chk(ehci_comp === `UPR_COMP_RST && ehci_cf === 1'b0, "system reset regs");
      sys_reset = 1'b0;
      two_port_mode = 1'b1;
      repeat (4) @(negedge clock);
      own_wr(1'b1, 1'b1, 4'hF, 4'h0);
      wait_own(4'h3);
      send(1, 1, 1'b0);
      send(0, 3, 1'b0);
      send(0, 1, 1'b1);
      @(negedge clock);
      rst = 1'b1;
      @(negedge clock);
      chk(port_owner_hs === 4'h0, "mid-run reset");
      rst = 1'b0;
      repeat (3) @(negedge clock);
      chk(port_owner_hs === 4'h0 && ehci_comp === `UPR_COMP_RST && ehci_cf === 1'b0,
          "after mid-run reset");
      chk(exp_q.size() == 0, "expected transmit missing");
      end_of_test();
   end
endmodule : upr_router_tb_top
